// *** common/pio_pkg.sv ***
`default_nettype none

package pio_pkg;

  // ==========================================================================
  // Geometry
  localparam int NPORT = 11;
  localparam int PW = 8;
  localparam int NPIN = 88;
  localparam int NGRP = 22;
  localparam int AW = 10;
  localparam int DW = 8;
  localparam int P1_IDX = 1;

  // ==========================================================================
  // Register offsets
  localparam logic [9:0] ADDR_MODE = 10'h004;
  localparam logic [9:0] ADDR_PUR_A = 10'h360;
  localparam logic [9:0] ADDR_PUR_B = 10'h361;
  localparam logic [9:0] ADDR_PUR_C = 10'h362;
  localparam logic [9:0] ADDR_PCTRL = 10'h366;
  localparam logic [9:0] ADDR_DATA_BASE = 10'h3C0;
  localparam logic [9:0] ADDR_DIR_BASE = 10'h3D0;
  localparam logic [9:0] NPORT_A = 10'h00B;

  // ==========================================================================
  // Field positions and reset values
  localparam int PU_P4HI_BIT = 1;
  localparam int P1_SEL_BIT = 0;
  localparam int MODE_BUS_BIT = 0;
  localparam int PUR_C_W = 6;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MEMEXP = 2'h1;
  localparam logic [1:0] MODE_MICRO = 2'h3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] PUR_B_BUS_RST = 8'h02;

  // ==========================================================================
  // Pin masks, bit k is port k/8 pin k%8
  localparam logic [87:0] NO_PULL_MASK = 88'h00_0020_0300_0000_0000_0000;
  localparam logic [87:0] INPUT_ONLY_MASK = 88'h00_0020_0000_0000_0000_0000;
  localparam logic [87:0] BUS_PULL_OFF_MASK = 88'h00_0000_0000_FF0F_FFFF_FFFF;
  localparam logic [87:0] BUS_PIN_DEFAULT = 88'h00_0000_0000_FFFF_FFFF_FFFF;

endpackage

`default_nettype wire

// *** rtl/pio_sync.sv ***
`default_nettype none

// Two-stage synchroniser; only the second stage leaves the module.
module pio_sync #(
  parameter int W = 88
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pio_sync_st_t;

  pio_sync_st_t q;
  pio_sync_st_t d;

  always_comb
  begin
    d = q;
    d.s1 = d_in;
    d.s2 = q.s1;
    if (!rst_n_in)
    begin
      d = '0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    q <= d;
  end

  assign q_out = q.s2;

endmodule

`default_nettype wire

// *** rtl/pio_port_cell.sv ***
`default_nettype none

// Per-port read path and write masking, purely combinational.
module pio_port_cell (
  input wire logic [7:0] dir_in,
  input wire logic [7:0] latch_in,
  input wire logic [7:0] pin_sync_in,
  input wire logic latch_sel_in,
  input wire logic [7:0] lock_in,
  input wire logic [7:0] input_only_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rd_val_out,
  output logic [7:0] dir_wr_out,
  output logic [7:0] latch_wr_out
);

  logic [7:0] use_latch;

  always_comb
  begin
    use_latch = (dir_in | {8{latch_sel_in}}) & ~input_only_in;
    rd_val_out = (use_latch & latch_in) | (~use_latch & pin_sync_in);
    dir_wr_out = (dir_in & lock_in) | (wdata_in & ~lock_in);
    latch_wr_out = (latch_in & lock_in) | (wdata_in & ~lock_in);
  end

endmodule

`default_nettype wire

// *** rtl/pio_top.sv ***
`default_nettype none

module pio_top #(
  parameter logic [87:0] BUS_PIN_MASK = pio_pkg::BUS_PIN_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic soft_rst_in,
  input wire logic boot_mode_pin_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [87:0] pin_in_in,
  input wire logic [87:0] periph_oe_in,
  input wire logic [87:0] periph_dout_in,
  output logic [87:0] pin_out_out,
  output logic [87:0] pin_oe_out,
  output logic [87:0] pullup_en_out,
  output logic bus_mode_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [10:0][7:0] dir;
    logic [10:0][7:0] lat;
    logic [7:0] pur_a;
    logic [7:0] pur_b;
    logic [5:0] pur_c;
    logic p1_sel;
    logic [1:0] mode;
    logic [7:0] rdata;
    logic [87:0] pout;
    logic [87:0] poe;
    logic [87:0] pu;
    logic bus;
  } pio_state_t;

  pio_state_t q;
  pio_state_t d;

  logic [87:0] pin_sync;
  logic [87:0] lock;
  logic [10:0][7:0] rd_val;
  logic [10:0][7:0] dir_w;
  logic [10:0][7:0] lat_w;
  logic bus_mode;
  logic [9:0] dir_off;
  logic [9:0] dat_off;
  logic dir_hit;
  logic dat_hit;
  logic [21:0] grp;

  // ==========================================================================
  // Input synchroniser
  pio_sync #(
    .W(pio_pkg::NPIN)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(pin_in_in),
    .q_out(pin_sync)
  );

  assign bus_mode = q.mode[pio_pkg::MODE_BUS_BIT];
  assign lock = bus_mode ? BUS_PIN_MASK : '0;

  // ==========================================================================
  // Port cells
  for (genvar i = 0; i < pio_pkg::NPORT; i++)
  begin : g_port
    pio_port_cell u_cell (
      .dir_in(q.dir[i]),
      .latch_in(q.lat[i]),
      .pin_sync_in(pin_sync[i*8 +: 8]),
      .latch_sel_in((i == pio_pkg::P1_IDX) ? q.p1_sel : 1'b0),
      .lock_in(lock[i*8 +: 8]),
      .input_only_in(pio_pkg::INPUT_ONLY_MASK[i*8 +: 8]),
      .wdata_in(wdata_in),
      .rd_val_out(rd_val[i]),
      .dir_wr_out(dir_w[i]),
      .latch_wr_out(lat_w[i])
    );
  end

  // ==========================================================================
  // Address decode
  assign dir_off = addr_in - pio_pkg::ADDR_DIR_BASE;
  assign dat_off = addr_in - pio_pkg::ADDR_DATA_BASE;
  assign dir_hit = (addr_in >= pio_pkg::ADDR_DIR_BASE) &&
                   (dir_off < pio_pkg::NPORT_A);
  assign dat_hit = (addr_in >= pio_pkg::ADDR_DATA_BASE) &&
                   (dat_off < pio_pkg::NPORT_A);
  assign grp = {q.pur_c, q.pur_b, q.pur_a};

  // ==========================================================================
  // Next state
  always_comb
  begin
    d = q;
    d.bus = bus_mode;
    // Register writes complete on this edge.
    if (wr_in)
    begin
      if (dir_hit)
      begin
        d.dir[dir_off[3:0]] = dir_w[dir_off[3:0]];
      end
      else if (dat_hit)
      begin
        d.lat[dat_off[3:0]] = lat_w[dat_off[3:0]];
      end
      else if (addr_in == pio_pkg::ADDR_PUR_A)
      begin
        d.pur_a = wdata_in;
      end
      else if (addr_in == pio_pkg::ADDR_PUR_B)
      begin
        d.pur_b = wdata_in;
      end
      else if (addr_in == pio_pkg::ADDR_PUR_C)
      begin
        d.pur_c = wdata_in[pio_pkg::PUR_C_W-1:0];
      end
      else if (addr_in == pio_pkg::ADDR_PCTRL)
      begin
        d.p1_sel = wdata_in[pio_pkg::P1_SEL_BIT];
      end
      else if (addr_in == pio_pkg::ADDR_MODE)
      begin
        d.mode = wdata_in[1:0];
        // Leaving single-chip mode for a mode with bit 0 set turns on the port 4 high pull-ups.
        if (q.mode == pio_pkg::MODE_SINGLE &&
            wdata_in[pio_pkg::MODE_BUS_BIT])
        begin
          d.pur_b[pio_pkg::PU_P4HI_BIT] = 1'b1;
        end
      end
    end
    // Read data stand for exactly the cycle after the strobe.
    d.rdata = pio_pkg::REG_RST;
    if (rd_in)
    begin
      if (dir_hit)
      begin
        d.rdata = q.dir[dir_off[3:0]];
      end
      else if (dat_hit)
      begin
        d.rdata = rd_val[dat_off[3:0]];
      end
      else if (addr_in == pio_pkg::ADDR_PUR_A)
      begin
        d.rdata = q.pur_a;
      end
      else if (addr_in == pio_pkg::ADDR_PUR_B)
      begin
        d.rdata = q.pur_b;
      end
      else if (addr_in == pio_pkg::ADDR_PUR_C)
      begin
        d.rdata = {2'h0, q.pur_c};
      end
      else if (addr_in == pio_pkg::ADDR_PCTRL)
      begin
        d.rdata = {7'h00, q.p1_sel};
      end
      else if (addr_in == pio_pkg::ADDR_MODE)
      begin
        d.rdata = {6'h00, q.mode};
      end
    end
    // Pin drivers. The input-only pin and locked bus pins are never driven
    // from the latch; the external bus controller owns the locked ones.
    d.poe = (q.dir & ~pio_pkg::INPUT_ONLY_MASK & ~lock) |
            periph_oe_in;
    d.pout = (periph_oe_in & periph_dout_in) |
             (~periph_oe_in & q.lat);
    for (int k = 0; k < pio_pkg::NPIN; k++)
    begin
      d.pu[k] = grp[k/4] & ~q.dir[k/8][k%8] & ~periph_oe_in[k] &
                ~pio_pkg::NO_PULL_MASK[k] &
                ~(bus_mode & pio_pkg::BUS_PULL_OFF_MASK[k]);
    end
    // Resets. The mode survives a soft reset and steers pull-up B.
    if (!rst_n_in)
    begin
      d = '0;
      d.mode = boot_mode_pin_in ? pio_pkg::MODE_MICRO
                                : pio_pkg::MODE_SINGLE;
      d.pur_b = boot_mode_pin_in ? pio_pkg::PUR_B_BUS_RST
                                 : pio_pkg::REG_RST;
    end
    else if (soft_rst_in)
    begin
      d = '0;
      d.mode = q.mode;
      d.bus = bus_mode;
      d.pur_b = bus_mode ? pio_pkg::PUR_B_BUS_RST
                         : pio_pkg::REG_RST;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    q <= d;
  end

  assign rdata_out = q.rdata;
  assign pin_out_out = q.pout;
  assign pin_oe_out = q.poe;
  assign pullup_en_out = q.pu;
  assign bus_mode_out = q.bus;

  // ==========================================================================
  // Assertions
  property p_dir_sets_oe;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    q.dir[6][0] && !periph_oe_in[48] && !soft_rst_in |=> pin_oe_out[48];
  endproperty
  a_dir_sets_oe: assert property (p_dir_sets_oe)
    else $error("Output direction did not enable the pin driver.");

  property p_bus_dir_lock;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    bus_mode && wr_in && addr_in == pio_pkg::ADDR_DIR_BASE &&
    BUS_PIN_MASK[7:0] == 8'hFF && !soft_rst_in
    |=> q.dir[0] == $past(q.dir[0]);
  endproperty
  a_bus_dir_lock: assert property (p_bus_dir_lock)
    else $error("Direction of a bus pin changed in bus mode.");

  property p_bus_lat_lock;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    bus_mode && wr_in && addr_in == pio_pkg::ADDR_DATA_BASE &&
    BUS_PIN_MASK[7:0] == 8'hFF && !soft_rst_in
    |=> q.lat[0] == $past(q.lat[0]);
  endproperty
  a_bus_lat_lock: assert property (p_bus_lat_lock)
    else $error("Latch of a bus pin changed in bus mode.");

  property p_rd_input;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == pio_pkg::ADDR_DATA_BASE + 10'h006 &&
    q.dir[6] == 8'h00 && !soft_rst_in
    |=> rdata_out == $past(pin_sync[55:48]);
  endproperty
  a_rd_input: assert property (p_rd_input)
    else $error("Input port read did not return the pin level.");

  property p_rd_output;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == pio_pkg::ADDR_DATA_BASE + 10'h006 &&
    q.dir[6] == 8'hFF && !soft_rst_in
    |=> rdata_out == $past(q.lat[6]);
  endproperty
  a_rd_output: assert property (p_rd_output)
    else $error("Output port read did not return the latch.");

  property p_pull_input_only;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !soft_rst_in |=> (pullup_en_out & $past(q.dir)) == 88'h0;
  endproperty
  a_pull_input_only: assert property (p_pull_input_only)
    else $error("Pull-up connected to an output pin.");

  property p_bus_no_pull;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    bus_mode |=>
    (pullup_en_out & pio_pkg::BUS_PULL_OFF_MASK) == 88'h0;
  endproperty
  a_bus_no_pull: assert property (p_bus_no_pull)
    else $error("Pull-up on a bus port in bus mode.");

  property p_p1_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == pio_pkg::ADDR_DATA_BASE + 10'h001 &&
    q.p1_sel && !soft_rst_in
    |=> rdata_out == $past(q.lat[1]);
  endproperty
  a_p1_latch: assert property (p_p1_latch)
    else $error("Port 1 latch select ignored on read.");

  property p_p7_no_pull;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    pullup_en_out[57:56] == 2'h0;
  endproperty
  a_p7_no_pull: assert property (p_p7_no_pull)
    else $error("Pull-up on port 7 pin 0 or 1.");

  property p_p85_input;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !periph_oe_in[69] |=> !pullup_en_out[69] && !pin_oe_out[69];
  endproperty
  a_p85_input: assert property (p_p85_input)
    else $error("Port 8 pin 5 pulled up or driven.");

  property p_mode_sets_pu;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == pio_pkg::ADDR_MODE &&
    q.mode == pio_pkg::MODE_SINGLE && wdata_in[0] && !soft_rst_in
    |=> q.pur_b[pio_pkg::PU_P4HI_BIT] && q.mode[pio_pkg::MODE_BUS_BIT];
  endproperty
  a_mode_sets_pu: assert property (p_mode_sets_pu)
    else $error("Port 4 high pull-up not set on mode change.");

  property p_hw_reset_pur;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |->
    q.pur_b == ($past(boot_mode_pin_in) ? 8'h02 : 8'h00);
  endproperty
  a_hw_reset_pur: assert property (p_hw_reset_pur)
    else $error("Pull-up B wrong after hardware reset.");

  property p_sw_reset_pur;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    soft_rst_in |=>
    q.pur_b == ($past(q.mode[0]) ? 8'h02 : 8'h00) && q.dir == '0;
  endproperty
  a_sw_reset_pur: assert property (p_sw_reset_pur)
    else $error("Pull-up B wrong after soft reset.");

endmodule

`default_nettype wire

// *** verification/pio_pin_model.sv ***
`default_nettype none

// =============================================================
// External pins: device driver, outside driver, pull-up, float.
module pio_pin_model (
  input wire logic core_clk_in,
  input wire logic [87:0] pin_out_in,
  input wire logic [87:0] pin_oe_in,
  input wire logic [87:0] pullup_en_in,
  input wire logic [87:0] ext_val_in,
  input wire logic [87:0] ext_drv_in,
  output logic [87:0] pin_lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [87:0] float_v;
  // A floating pin never holds its last level, so a missed pull-up shows.
  assign float_v = {44{2'h2}} ^ {88{core_clk_in}};
  assign pin_lvl_out = (pin_oe_in & pin_out_in)
    | (~pin_oe_in & ext_drv_in & ext_val_in)
    | (~pin_oe_in & ~ext_drv_in & (pullup_en_in | float_v));
endmodule

`default_nettype wire

// *** verification/pio_top_tb.sv ***
`default_nettype none
`define CHK(n, e, g) check_val(n, 88'(e), 88'(g))

// =============================================================
// Bench
module pio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic soft_rst = 1'h0;
  logic boot = 1'h0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'h0;
  logic rd_s = 1'h0;
  logic [7:0] rdata;
  logic [87:0] poe = '0;
  logic [87:0] pdo = '0;
  logic [87:0] ext = '0;
  logic [87:0] pin_lvl, pout, oe, pu;
  logic bus;
  logic [87:0] dir_m, lat_m;
  logic [23:0] pur_m;
  logic [1:0] mode_m;
  logic pctrl_m;
  logic [31:0] lfsr_s = 32'hE506;
  int n_mismatch = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  pio_top i_pio_top (.core_clk_in(clk), .rst_n_in(rst_n),
    .soft_rst_in(soft_rst), .boot_mode_pin_in(boot), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .pin_in_in(pin_lvl), .periph_oe_in(poe), .periph_dout_in(pdo),
    .pin_out_out(pout), .pin_oe_out(oe), .pullup_en_out(pu),
    .bus_mode_out(bus));
  pio_pin_model i_pio_pin_model (.core_clk_in(clk), .pin_out_in(pout),
    .pin_oe_in(oe), .pullup_en_in(pu), .ext_val_in(ext),
    .ext_drv_in({88{1'h1}}), .pin_lvl_out(pin_lvl));

  function automatic logic [31:0] rnd();
    lfsr_s = {lfsr_s[30:0], 1'h0} ^ (lfsr_s[31] ? 32'h0040_0007 : 32'h0);
    return lfsr_s;
  endfunction

  function automatic logic [87:0] exp_oe();
    logic [87:0] lk;
    lk = mode_m[0] ? pio_pkg::BUS_PIN_DEFAULT : 88'h0;
    return (dir_m & ~pio_pkg::INPUT_ONLY_MASK & ~lk) | poe;
  endfunction

  function automatic logic [87:0] exp_pu();
    logic [87:0] r;
    logic [87:0] off;
    for (int k = 0; k < 88; k++)
      r[k] = pur_m[k/4] & ~dir_m[k] & ~poe[k];
    off = mode_m[0] ? pio_pkg::BUS_PULL_OFF_MASK : 88'h0;
    return r & ~pio_pkg::NO_PULL_MASK & ~off;
  endfunction

  function automatic logic [7:0] exp_rd(input int p);
    logic [7:0] s;
    s = dir_m[p*8+:8] | ((p == 1 && pctrl_m) ? 8'hFF : 8'h00);
    s = s & ~pio_pkg::INPUT_ONLY_MASK[p*8+:8];
    return (s & lat_m[p*8+:8]) | (~s & ext[p*8+:8]);
  endfunction

  task automatic check_val(input string n, input logic [87:0] e,
                           input logic [87:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    int p;
    logic [7:0] lk;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
    p = int'(a[3:0]);
    lk = mode_m[0] ? pio_pkg::BUS_PIN_DEFAULT[p*8+:8] : 8'h00;
    if (a[9:4] == pio_pkg::ADDR_DIR_BASE[9:4] && p < pio_pkg::NPORT)
      dir_m[p*8+:8] = (dir_m[p*8+:8] & lk) | (d & ~lk);
    if (a[9:4] == pio_pkg::ADDR_DATA_BASE[9:4] && p < pio_pkg::NPORT)
      lat_m[p*8+:8] = (lat_m[p*8+:8] & lk) | (d & ~lk);
    if (a == pio_pkg::ADDR_PUR_A)
      pur_m[7:0] = d;
    if (a == pio_pkg::ADDR_PUR_B)
      pur_m[15:8] = d;
    if (a == pio_pkg::ADDR_PUR_C)
      pur_m[23:16] = {2'h0, d[5:0]};
    if (a == pio_pkg::ADDR_PCTRL)
      pctrl_m = d[0];
    if (a == pio_pkg::ADDR_MODE)
    begin
      if (mode_m == 2'h0 && d[0])
        pur_m[9] = 1'h1;
      mode_m = d[1:0];
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1;
    `CHK("rdata", e, rdata);
    // Read data must fall back to zero once their single cycle is over.
    @(posedge clk);
    #1;
    `CHK("rdata_idle", 8'h00, rdata);
  endtask

  task automatic clr_model(input logic pb);
    dir_m = '0;
    lat_m = '0;
    pur_m = {8'h0, 6'h0, pb, 1'h0, 8'h0};
    pctrl_m = 1'h0;
  endtask

  task automatic chk_pins();
    repeat (3) @(posedge clk);
    #1;
    `CHK("pin_oe", exp_oe(), oe);
    `CHK("pin_out", (poe & pdo) | (~poe & lat_m), pout);
    `CHK("pullup", exp_pu(), pu);
    `CHK("bus_mode", mode_m[0], bus);
  endtask

  task automatic sweep();
    for (int p = 0; p < pio_pkg::NPORT; p++)
    begin
      wr(pio_pkg::ADDR_DIR_BASE + 10'(p), 8'(rnd()));
      wr(pio_pkg::ADDR_DATA_BASE + 10'(p), 8'(rnd()));
    end
    ext <= 88'({rnd(), rnd(), rnd()});
    repeat (4) @(posedge clk);
    for (int p = 0; p < pio_pkg::NPORT; p++)
    begin
      rd(pio_pkg::ADDR_DIR_BASE + 10'(p), dir_m[p*8+:8]);
      rd(pio_pkg::ADDR_DATA_BASE + 10'(p), exp_rd(p));
    end
    chk_pins();
  endtask

  task automatic hard_reset(input logic b);
    @(posedge clk);
    boot <= b;
    rst_n <= 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    clr_model(b);
    mode_m = b ? pio_pkg::MODE_MICRO : pio_pkg::MODE_SINGLE;
  endtask

  task automatic soft_reset();
    @(posedge clk);
    soft_rst <= 1'h1;
    @(posedge clk);
    soft_rst <= 1'h0;
    clr_model(mode_m[0]);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    hard_reset(1'h0);
    rd(pio_pkg::ADDR_PUR_B, 8'h00);
    rd(10'h3FF, 8'h00);
    for (int p = 0; p < pio_pkg::NPORT; p++)
      rd(pio_pkg::ADDR_DIR_BASE + 10'(p), 8'h00);
    wr(pio_pkg::ADDR_PUR_A, 8'(rnd()));
    wr(pio_pkg::ADDR_PUR_B, 8'hFF);
    wr(pio_pkg::ADDR_PUR_C, 8'hFF);
    rd(pio_pkg::ADDR_PUR_C, 8'h3F);
    sweep();
    wr(pio_pkg::ADDR_PCTRL, 8'hFF);
    rd(pio_pkg::ADDR_PCTRL, 8'h01);
    sweep();
    @(posedge clk);
    poe <= 88'({rnd(), rnd(), rnd()});
    pdo <= 88'({rnd(), rnd(), rnd()});
    chk_pins();
    @(posedge clk);
    poe <= '0;
    wr(pio_pkg::ADDR_PUR_B, 8'h00);
    wr(pio_pkg::ADDR_MODE, 8'h01);
    rd(pio_pkg::ADDR_PUR_B, 8'h02);
    wr(pio_pkg::ADDR_PUR_A, 8'hFF);
    sweep();
    soft_reset();
    rd(pio_pkg::ADDR_PUR_B, 8'h02);
    rd(pio_pkg::ADDR_MODE, 8'h01);
    wr(pio_pkg::ADDR_MODE, 8'h00);
    soft_reset();
    rd(pio_pkg::ADDR_PUR_B, 8'h00);
    hard_reset(1'h1);
    rd(pio_pkg::ADDR_PUR_B, 8'h02);
    rd(pio_pkg::ADDR_MODE, 8'h03);
    chk_pins();
    end_of_test();
  end
endmodule

`undef CHK
`default_nettype wire
